// ==== inc/med_regs.svh ====
/*
 motion event detector: register field positions, reset values and scale constants.
 assumes 16-bit two's complement samples where full scale maps to 0x8000.
*/
`ifndef MED_REGS_SVH
`define MED_REGS_SVH

// motion source register fields
`define MED_MSRC_FF_BIT 5
`define MED_MSRC_WU_BIT 3
`define MED_MSRC_X_BIT 2
`define MED_MSRC_Y_BIT 1
`define MED_MSRC_Z_BIT 0
// orientation source register fields
`define MED_OSRC_CHG_BIT 6
`define MED_OSRC_POS_LSB 0
// reset values
`define MED_MSRC_RST 8'h00
`define MED_OSRC_RST 8'h00
`define MED_POS_RST 6'h00
// drop zone amplitudes per code, in 31.25 mg units
`define MED_FF_AMP0 5'h05
`define MED_FF_AMP1 5'h07
`define MED_FF_AMP2 5'h08
`define MED_FF_AMP3 5'h0A
`define MED_FF_AMP4 5'h0B
`define MED_FF_AMP5 5'h0D
`define MED_FF_AMP6 5'h0F
`define MED_FF_AMP7 5'h10
// shift from 31.25 mg or fs/64 units to counts at 2 g scale
`define MED_FF_UNIT_SHIFT 4'h9
`define MED_WU_UNIT_SHIFT 4'h9
// one g in counts at 2 g scale
`define MED_ONE_G 24'h00_4000
// sine of angle, scaled by 256: 80, 70, 60, 50 degrees
`define MED_SIN80 24'h00_00FC
`define MED_SIN70 24'h00_00F1
`define MED_SIN60 24'h00_00DE
`define MED_SIN50 24'h00_00C4
`define MED_SIN_SHIFT 4'h8
// counter limits
`define MED_FF_CNT_MAX 6'h3F
`define MED_WU_CNT_MAX 3'h7

`endif

// ==== inc/med_pkg.sv ====
/*
 motion event detector types.
 assumes nothing beyond a systemverilog compiler.
*/
package med_pkg;
   typedef logic signed [15:0] med_smp_t;
   typedef logic [15:0] med_mag_t;
   typedef logic [5:0] med_pos_t;
   // full scale selection, 2 g to 16 g
   typedef enum logic [1:0] {
      MED_FS_2G,
      MED_FS_4G,
      MED_FS_8G,
      MED_FS_16G
   } med_fs_e;
endpackage

// ==== design/med_detector.sv ====
/*
 motion event detector: free-fall, wake-up and 6d/4d orientation on one
 interrupt pin, with latched and routed source flags cleared by read strobes.
 assumes samples arrive with a one-cycle valid strobe on i_ref_clk, config
 inputs come from register flops on the same clock, read strobes are one cycle.
*/
`timescale 1ns/1ps
`include "med_regs.svh"

module med_detector
   import med_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // samples
   input wire logic i_sample_valid,
   input wire med_pkg::med_smp_t i_acc_x,
   input wire med_pkg::med_smp_t i_acc_y,
   input wire med_pkg::med_smp_t i_acc_z,
   input wire med_pkg::med_smp_t i_slope_x,
   input wire med_pkg::med_smp_t i_slope_y,
   input wire med_pkg::med_smp_t i_slope_z,
   // configuration
   input wire med_pkg::med_fs_e i_full_scale,
   input wire logic i_latch_irq_sel,
   input wire logic i_route_freefall_pin_one,
   input wire logic i_route_motion_pin_one,
   input wire logic i_route_orientation_pin_one,
   input wire logic [2:0] i_drop_threshold_code,
   input wire logic [5:0] i_drop_duration_count,
   input wire logic [5:0] i_motion_threshold_code,
   input wire logic [1:0] i_motion_duration_code,
   input wire logic [1:0] i_orientation_angle_code,
   input wire logic i_planar_orientation_enable,
   // source register reads
   input wire logic i_motion_source_rd,
   input wire logic i_orientation_source_rd,
   // outputs
   output logic [7:0] o_motion_source,
   output logic [7:0] o_orientation_source,
   output logic o_irq_pin_one
);
   import med_pkg::*;

   function automatic med_mag_t mag(input med_smp_t v);
      mag = v[15] ? med_mag_t'(~v + 16'sh0001) : med_mag_t'(v);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // thresholds
   logic [4:0] ff_amp;
   med_mag_t ff_thr, wu_thr, or_thr;
   logic [23:0] sin_k, g_cnt, or_prod;
   always_comb begin
      case (i_drop_threshold_code)
         3'h0: ff_amp = `MED_FF_AMP0;
         3'h1: ff_amp = `MED_FF_AMP1;
         3'h2: ff_amp = `MED_FF_AMP2;
         3'h3: ff_amp = `MED_FF_AMP3;
         3'h4: ff_amp = `MED_FF_AMP4;
         3'h5: ff_amp = `MED_FF_AMP5;
         3'h6: ff_amp = `MED_FF_AMP6;
         default: ff_amp = `MED_FF_AMP7;
      endcase
      case (i_orientation_angle_code)
         2'h0: sin_k = `MED_SIN80;
         2'h1: sin_k = `MED_SIN70;
         2'h2: sin_k = `MED_SIN60;
         default: sin_k = `MED_SIN50;
      endcase
   end
   assign ff_thr = med_mag_t'({11'h000, ff_amp} << (`MED_FF_UNIT_SHIFT - {2'h0, i_full_scale}));
   assign wu_thr = med_mag_t'({10'h000, i_motion_threshold_code} << `MED_WU_UNIT_SHIFT);
   assign g_cnt = `MED_ONE_G >> i_full_scale;
   assign or_prod = 24'((g_cnt * sin_k) >> `MED_SIN_SHIFT);
   assign or_thr = or_prod[15:0];

   ////////////////////////////////////////////////////////////////////
   // live conditions
   logic smp, ff_zone, ff_live, wu_over, wu_live, or_valid, or_evt;
   logic [2:0] wu_ax, or_ov;
   logic [5:0] ff_cnt_q, ff_new;
   logic [2:0] wu_cnt_q, wu_new;
   med_pos_t or_pos, or_pos_q;
   assign smp = i_sample_valid;
   assign ff_zone = (mag(i_acc_x) < ff_thr) && (mag(i_acc_y) < ff_thr)
                    && (mag(i_acc_z) < ff_thr);
   assign ff_new = !ff_zone ? 6'h00 : (ff_cnt_q == `MED_FF_CNT_MAX) ? ff_cnt_q
                   : ff_cnt_q + 6'h01;
   assign ff_live = ff_zone && (ff_new >= i_drop_duration_count);
   assign wu_ax = {mag(i_slope_x) > wu_thr, mag(i_slope_y) > wu_thr,
                   mag(i_slope_z) > wu_thr};
   assign wu_over = |wu_ax;
   assign wu_new = !wu_over ? 3'h0 : (wu_cnt_q == `MED_WU_CNT_MAX) ? wu_cnt_q
                   : wu_cnt_q + 3'h1;
   assign wu_live = wu_over && (wu_new > {1'b0, i_motion_duration_code});
   assign or_ov = {mag(i_acc_z) > or_thr, mag(i_acc_y) > or_thr, mag(i_acc_x) > or_thr};
   always_comb begin
      if (i_planar_orientation_enable) begin
         or_valid = or_ov[1] ^ or_ov[0];
      end else begin
         or_valid = (or_ov == 3'b001) || (or_ov == 3'b010) || (or_ov == 3'b100);
      end
      or_pos = {or_ov[2] & ~i_acc_z[15] & ~i_planar_orientation_enable,
                or_ov[2] & i_acc_z[15] & ~i_planar_orientation_enable,
                or_ov[1] & ~i_acc_y[15], or_ov[1] & i_acc_y[15],
                or_ov[0] & ~i_acc_x[15], or_ov[0] & i_acc_x[15]};
   end
   assign or_evt = or_valid && (or_pos != or_pos_q);

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         ff_cnt_q <= 6'h00;
         wu_cnt_q <= 3'h0;
      end else if (smp) begin
         ff_cnt_q <= ff_new;
         wu_cnt_q <= wu_new;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         or_pos_q <= `MED_POS_RST;
      end else if (smp && or_valid) begin
         or_pos_q <= or_pos;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags: latch acts only when routed
   logic lat_ff, lat_wu, lat_or;
   logic ff_flag_q, wu_flag_q, or_flag_q, ff_flag_d, wu_flag_d, or_flag_d;
   logic [2:0] wu_axis_q, wu_axis_d;
   assign lat_ff = i_latch_irq_sel && i_route_freefall_pin_one;
   assign lat_wu = i_latch_irq_sel && i_route_motion_pin_one;
   assign lat_or = i_latch_irq_sel && i_route_orientation_pin_one;

   always_comb begin
      ff_flag_d = ff_flag_q;
      wu_flag_d = wu_flag_q;
      wu_axis_d = wu_axis_q;
      or_flag_d = or_flag_q;
      if (lat_ff) begin
         ff_flag_d = (smp && ff_live) || (ff_flag_q && !i_motion_source_rd);
      end else if (smp) begin
         ff_flag_d = ff_live;
      end
      if (lat_wu) begin
         wu_flag_d = (smp && wu_live) || (wu_flag_q && !i_motion_source_rd);
         if (smp && wu_live) begin
            wu_axis_d = wu_axis_q | wu_ax;
         end else if (i_motion_source_rd) begin
            wu_axis_d = 3'h0;
         end
      end else if (smp) begin
         wu_flag_d = wu_live;
         wu_axis_d = wu_live ? wu_ax : 3'h0;
      end
      if (lat_or) begin
         or_flag_d = (smp && or_evt) || (or_flag_q && !i_orientation_source_rd);
      end else if (smp) begin
         or_flag_d = or_evt;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         ff_flag_q <= 1'b0;
         wu_flag_q <= 1'b0;
         wu_axis_q <= 3'h0;
         or_flag_q <= 1'b0;
      end else begin
         ff_flag_q <= ff_flag_d;
         wu_flag_q <= wu_flag_d;
         wu_axis_q <= wu_axis_d;
         or_flag_q <= or_flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt pin
   logic [2:0] route_v;
   assign route_v = {i_route_freefall_pin_one, i_route_motion_pin_one,
                     i_route_orientation_pin_one};
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_irq_pin_one <= 1'b0;
      end else begin
         o_irq_pin_one <= |({ff_flag_d, wu_flag_d, or_flag_d} & route_v);
      end
   end

   always_comb begin
      o_motion_source = `MED_MSRC_RST;
      o_motion_source[`MED_MSRC_FF_BIT] = ff_flag_q;
      o_motion_source[`MED_MSRC_WU_BIT] = wu_flag_q;
      o_motion_source[`MED_MSRC_X_BIT] = wu_axis_q[2];
      o_motion_source[`MED_MSRC_Y_BIT] = wu_axis_q[1];
      o_motion_source[`MED_MSRC_Z_BIT] = wu_axis_q[0];
      o_orientation_source = `MED_OSRC_RST;
      o_orientation_source[`MED_OSRC_CHG_BIT] = or_flag_q;
      o_orientation_source[`MED_OSRC_POS_LSB +: 6] = or_pos_q;
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_or_fire;
      smp && or_evt && !lat_or;
   endsequence
   sequence s_or_quiet;
      smp && !or_evt && !lat_or;
   endsequence

   property p_ff_follow;
      !lat_ff && smp && !ff_live |=> !ff_flag_q;
   endproperty
   a_ff_follow: assert property (p_ff_follow) else $error("ff flag stuck");
   property p_ff_hold;
      ff_flag_q && lat_ff && !i_motion_source_rd |=> ff_flag_q;
   endproperty
   a_ff_hold: assert property (p_ff_hold) else $error("ff latch lost");
   property p_drop_duration_count;
      $rose(ff_flag_q) |-> $past(ff_new) >= $past(i_drop_duration_count)
                           && $past(ff_zone);
   endproperty
   a_drop_duration_count: assert property (p_drop_duration_count) else $error("ff too early");
   property p_wu_zero;
      smp && i_motion_duration_code == 2'h0 && wu_over |=> wu_flag_q;
   endproperty
   a_wu_zero: assert property (p_wu_zero) else $error("wake missed");
   property p_wu_axis;
      $rose(wu_flag_q) |-> wu_axis_q != 3'h0;
   endproperty
   a_wu_axis: assert property (p_wu_axis) else $error("no wake axis");
   property p_or_fire;
      s_or_fire |=> or_flag_q;
   endproperty
   a_or_fire: assert property (p_or_fire) else $error("orient missed");
   property p_or_quiet;
      s_or_quiet |=> !or_flag_q;
   endproperty
   a_or_quiet: assert property (p_or_quiet) else $error("orient too long");
   property p_or_planar;
      smp && i_planar_orientation_enable && or_valid |=> or_pos_q[5:4] == 2'b00;
   endproperty
   a_or_planar: assert property (p_or_planar) else $error("z in planar");
   property p_irq_or;
      1'b1 |=> o_irq_pin_one == |({ff_flag_q, wu_flag_q, or_flag_q} & $past(route_v));
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("pin not or");

   sequence s_ff_rd;
      ff_flag_q && lat_ff && i_motion_source_rd && !smp;
   endsequence
   sequence s_wu_held;
      wu_flag_q && lat_wu && !i_motion_source_rd;
   endsequence
   sequence s_or_held;
      or_flag_q && lat_or && !i_orientation_source_rd;
   endsequence

   property p_ff_clear;
      s_ff_rd |=> !ff_flag_q;
   endproperty
   a_ff_clear: assert property (p_ff_clear) else $error("ff read no clear");
   property p_ff_fire;
      smp && ff_live |=> ff_flag_q;
   endproperty
   a_ff_fire: assert property (p_ff_fire) else $error("ff missed");
   property p_wu_follow;
      !lat_wu && smp && !wu_over |=> !wu_flag_q;
   endproperty
   a_wu_follow: assert property (p_wu_follow) else $error("wake flag stuck");
   property p_wu_hold;
      s_wu_held |=> wu_flag_q;
   endproperty
   a_wu_hold: assert property (p_wu_hold) else $error("wake latch lost");
   property p_or_hold;
      s_or_held |=> or_flag_q;
   endproperty
   a_or_hold: assert property (p_or_hold) else $error("orient latch lost");
   property p_or_keep;
      smp && !or_valid |=> or_pos_q == $past(or_pos_q);
   endproperty
   a_or_keep: assert property (p_or_keep) else $error("orient moved");
endmodule

// ==== bench/med_host_model.sv ====
/*
 host processor model: issues one-cycle source register read strobes.
 assumes the bench calls read_src and the detector samples on i_ref_clk.
*/
`timescale 1ns/1ps
module med_host_model (
   // clock
   input wire logic i_ref_clk,
   // read strobes
   output logic o_motion_source_rd,
   output logic o_orientation_source_rd
);
   initial begin
      o_motion_source_rd = 1'b0;
      o_orientation_source_rd = 1'b0;
   end
   task automatic read_src(input logic orient);
      @(posedge i_ref_clk);
      if (orient) begin
         o_orientation_source_rd <= 1'b1;
      end else begin
         o_motion_source_rd <= 1'b1;
      end
      @(posedge i_ref_clk);
      o_motion_source_rd <= 1'b0;
      o_orientation_source_rd <= 1'b0;
   endtask
endmodule

// ==== bench/motion_event_detector_tb.sv ====
/*
 self-checking bench for the motion event detector.
 assumes med_detector, med_host_model and med_pkg are compiled first.
*/
`timescale 1ns/1ps
module motion_event_detector_tb;
   import med_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic sv = 1'b0;
   logic go = 1'b0;
   med_smp_t ax = '0, ay = '0, az = '0, sx = '0, sy = '0, sz = '0;
   logic lt = 1'b0, rf = 1'b0, rm = 1'b0, ro = 1'b0, pl = 1'b0, mrd, ord, irq;
   logic [2:0] fc = '0;
   logic [5:0] fd = '0, wc = '0;
   logic [1:0] wd = '0, ac = '0;
   med_fs_e fs = MED_FS_2G;
   logic [7:0] ms, os;
   logic [16:0] e;
   logic [16:0] exp_q[$];
   int err_count = 0, samples_checked = 0, cyc = 0;
   int unsigned rs;
   int am[8] = '{5, 7, 8, 10, 11, 13, 15, 16};
   int th[4] = '{16128, 15424, 14208, 12544};
   always #4 i_ref_clk = ~i_ref_clk;
   med_detector DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sample_valid(sv),
      .i_acc_x(ax), .i_acc_y(ay), .i_acc_z(az), .i_slope_x(sx), .i_slope_y(sy),
      .i_slope_z(sz), .i_full_scale(fs), .i_latch_irq_sel(lt),
      .i_route_freefall_pin_one(rf), .i_route_motion_pin_one(rm),
      .i_route_orientation_pin_one(ro), .i_drop_threshold_code(fc),
      .i_drop_duration_count(fd), .i_motion_threshold_code(wc),
      .i_motion_duration_code(wd), .i_orientation_angle_code(ac),
      .i_planar_orientation_enable(pl), .i_motion_source_rd(mrd),
      .i_orientation_source_rd(ord), .o_motion_source(ms), .o_orientation_source(os),
      .o_irq_pin_one(irq));
   med_host_model u_host (.i_ref_clk(i_ref_clk), .o_motion_source_rd(mrd),
      .o_orientation_source_rd(ord));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
      samples_checked++;
      if (x !== s) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   always @(negedge i_ref_clk) begin
      if (go) begin
         go = 1'b0;
         e = exp_q.pop_front();
         chk("motion_source", e[16:9], ms);
         chk("orientation_source", e[8:1], os);
         chk("irq_pin_one", {7'h00, e[0]}, {7'h00, irq});
      end
   end
   task automatic smp(input int x, y, z, s1, s2, s3, input logic [16:0] v);
      @(posedge i_ref_clk);
      ax <= med_smp_t'(x);
      ay <= med_smp_t'(y);
      az <= med_smp_t'(z);
      sx <= med_smp_t'(s1);
      sy <= med_smp_t'(s2);
      sz <= med_smp_t'(s3);
      sv <= 1'b1;
      exp_q.push_back(v);
      @(posedge i_ref_clk);
      sv <= 1'b0;
      go <= 1'b1;
   endtask
   task automatic rd(input logic o, input logic [16:0] v);
      exp_q.push_back(v);
      u_host.read_src(o);
      go <= 1'b1;
   endtask
   function automatic int rv();
      return int'($urandom_range(9998)) - 4999;
   endfunction
   task automatic tally_and_finish();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rs = $urandom(32'hdd99_cb44);
      repeat (6) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      exp_q.push_back(17'h0_0000);
      go <= 1'b1;
      {rf, rm, ro} <= 3'b111;
      wc <= 6'h02;
      smp(0, 0, 'h4000, 0, 0, 0, {8'h00, 8'h60, 1'b1});
      smp(0, 0, 'h4000, 0, 0, 0, {8'h00, 8'h20, 1'b0});
      smp(-'h4000, 0, 0, 0, 0, 0, {8'h00, 8'h41, 1'b1});
      pl <= 1'b1;
      smp(0, 0, 'h4000, 0, 0, 0, {8'h00, 8'h01, 1'b0});
      pl <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         ac <= 2'(k);
         smp(k[0] ? -th[k] - 1 : th[k] + 1, 0, 0, 0, 0, 0,
            {8'h00, k[0] ? 8'h41 : 8'h42, 1'b1});
         smp(th[k], 0, 0, 0, 0, 0, {8'h00, k[0] ? 8'h01 : 8'h02, 1'b0});
      end
      fd <= 6'h01;
      for (int k = 0; k < 8; k++) begin
         fc <= 3'(k);
         smp(am[k] * 512 - 1, 0, 0, 0, 0, 0, {8'h20, 8'h01, 1'b1});
         smp(am[k] * 512, 0, 0, 0, 0, 0, {8'h00, 8'h01, 1'b0});
      end
      fd <= 6'h02;
      fc <= 3'h3;
      smp(rv(), rv(), rv(), 0, 0, 0, {8'h00, 8'h01, 1'b0});
      smp(rv(), rv(), rv(), 0, 0, 0, {8'h20, 8'h01, 1'b1});
      smp(5120, 0, 0, 0, 0, 0, {8'h00, 8'h01, 1'b0});
      smp(rv(), rv(), rv(), 0, 0, 0, {8'h00, 8'h01, 1'b0});
      lt <= 1'b1;
      smp(rv(), rv(), rv(), 0, 0, 0, {8'h20, 8'h01, 1'b1});
      smp(6000, 0, 0, 0, 0, 0, {8'h20, 8'h01, 1'b1});
      rd(1'b0, {8'h00, 8'h01, 1'b0});
      rf <= 1'b0;
      smp(rv(), rv(), rv(), 0, 0, 0, {8'h00, 8'h01, 1'b0});
      smp(rv(), rv(), rv(), 0, 0, 0, {8'h20, 8'h01, 1'b0});
      smp(6000, 0, 0, 0, 0, 0, {8'h00, 8'h01, 1'b0});
      lt <= 1'b0;
      smp(6000, 0, 0, 0, -1025, 0, {8'h0A, 8'h01, 1'b1});
      smp(6000, 0, 0, 0, 1024, 0, {8'h00, 8'h01, 1'b0});
      for (int d = 1; d < 4; d++) begin
         wd <= 2'(d);
         for (int j = 0; j <= d; j++) begin
            smp(6000, 0, 0, 1025, 0, 0, (j == d) ? {8'h0C, 8'h01, 1'b1} : 17'h0_0002);
         end
         smp(6000, 0, 0, 0, 0, 0, {8'h00, 8'h01, 1'b0});
      end
      lt <= 1'b1;
      wd <= 2'h0;
      smp(6000, 0, 0, 0, 0, 2000, {8'h09, 8'h01, 1'b1});
      smp(6000, 0, 0, 0, 0, 0, {8'h09, 8'h01, 1'b1});
      rd(1'b0, {8'h00, 8'h01, 1'b0});
      smp(0, 'h4000, 0, 0, 0, 0, {8'h00, 8'h48, 1'b1});
      smp(0, 'h4000, 0, 0, 0, 0, {8'h00, 8'h48, 1'b1});
      rd(1'b1, {8'h00, 8'h08, 1'b0});
      lt <= 1'b0;
      rf <= 1'b1;
      fd <= 6'h01;
      fs <= MED_FS_4G;
      smp(2559, 0, 0, 0, 0, 0, {8'h20, 8'h08, 1'b1});
      smp(2560, 0, 0, 0, 0, 0, {8'h00, 8'h08, 1'b0});
      smp(0, 0, -6273, 1025, 0, 0, {8'h0C, 8'h50, 1'b1});
      pl <= 1'b1;
      smp(-7000, 0, 7000, 0, 0, 0, {8'h00, 8'h41, 1'b1});
      @(posedge i_ref_clk);
      tally_and_finish();
   end
endmodule
